// file: src/mpors_low_timer.v
// Counts milliseconds while an input stays low
`timescale 1ns/1ps
module mpors_low_timer #(
  parameter W = 16
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire tick,
  input wire lowIn,
  output reg [W-1:0] lowMs_r
);
  always @(posedge sys_clk) begin
    if (sys_rst || lowIn) begin
      lowMs_r <= {W{1'b0}};
    end else if (tick && lowMs_r != {W{1'b1}}) begin
      lowMs_r <= lowMs_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // mpors_low_timer

// file: src/mpors_map.vh
// Timing constants and state codes for the module power-off and reset sequencer
`ifndef MPORS_MAP_VH
`define MPORS_MAP_VH
`define MPORS_CLK_HZ 125000000
`define MPORS_TICK_HZ 1000
`define MPORS_TICK_DIV (`MPORS_CLK_HZ / `MPORS_TICK_HZ)
`define MPORS_ON_PULSE_MS 100
`define MPORS_OFF_PULSE_MS 2500
`define MPORS_OFF_DONE_MS 22000
`define MPORS_CMD_OFF_DONE_MS 15000
`define MPORS_RST_PULSE_MS 1000
`define MPORS_RESTART_READY_MS 27000
`define MPORS_ST_OFF 3'h0
`define MPORS_ST_BOOT 3'h1
`define MPORS_ST_ON 3'h2
`define MPORS_ST_SHUTDOWN 3'h3
`define MPORS_ST_RESTART 3'h4
`endif

// file: src/mpors_sequencer.v
// Power-on, power-off, reset and card-presence sequencing inside the module
`timescale 1ns/1ps
`include "mpors_map.vh"
// What this block does
// - Pin-requested shutdown lasts at least 22 s before the module reports off.
// - Shutdown command finishes after at least 15 s.
// - After restart command, command port is ready no sooner than 27 s.
// - With detection enabled, low card input means present, high means absent.
// - Card input pulled up internally, so unconnected reads absent.
// - Power control is low-active, pulled up; short pulse on, long pulse off.
module mpors_sequencer #(
  parameter TICK_DIV = `MPORS_TICK_DIV,
  parameter ON_PULSE_MS = `MPORS_ON_PULSE_MS,
  parameter OFF_PULSE_MS = `MPORS_OFF_PULSE_MS,
  parameter OFF_DONE_MS = `MPORS_OFF_DONE_MS,
  parameter CMD_OFF_DONE_MS = `MPORS_CMD_OFF_DONE_MS,
  parameter RST_PULSE_MS = `MPORS_RST_PULSE_MS,
  parameter RESTART_READY_MS = `MPORS_RESTART_READY_MS,
  parameter BOOT_MS = `MPORS_RESTART_READY_MS
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire powerCtrlIn,
  input wire resetReqIn,
  input wire card_presence_in,
  input wire shutdown_command,
  input wire restart_command,
  input wire card_detect_enable_command,
  input wire cardDetectArg,
  output reg moduleOn_r,
  output reg cmdPortReady_r,
  output reg cardPresent_r,
  output reg cardDetectEn_r,
  output wire powerCtrlPullUp,
  output wire cardPresencePullUp
);
  localparam ST_OFF = `MPORS_ST_OFF;
  localparam ST_BOOT = `MPORS_ST_BOOT;
  localparam ST_ON = `MPORS_ST_ON;
  localparam ST_SHUTDOWN = `MPORS_ST_SHUTDOWN;
  localparam ST_RESTART = `MPORS_ST_RESTART;

  // Sized copies of the millisecond limits; the wait timer keeps only 16 bits,
  // so limits must stay below 65536 ms or they wrap
  localparam [31:0] BOOT_LIM = BOOT_MS;
  localparam [31:0] OFF_LIM = OFF_DONE_MS;
  localparam [31:0] CMD_OFF_LIM = CMD_OFF_DONE_MS;
  localparam [31:0] RESTART_LIM = RESTART_READY_MS;

  // Saturating millisecond step shared by the reset and wait timers
  function [15:0] msStep;
    input [15:0] cnt;
    input en;
    begin
      if (en && cnt != 16'hFFFF) begin
        msStep = cnt + 16'h0001;
      end else begin
        msStep = cnt;
      end
    end
  endfunction

  // Pull-ups are always on: an open input reads high
  assign powerCtrlPullUp = 1'b1;
  assign cardPresencePullUp = 1'b1;

  // Two-stage synchronisers for the pins
  reg [1:0] pwrSync_r;
  reg [1:0] rstSync_r;
  reg [1:0] cardSync_r;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pwrSync_r <= 2'h3;
      rstSync_r <= 2'h3;
      cardSync_r <= 2'h3;
    end else begin
      pwrSync_r <= {pwrSync_r[0], powerCtrlIn};
      rstSync_r <= {rstSync_r[0], resetReqIn};
      cardSync_r <= {cardSync_r[0], card_presence_in};
    end
  end
  wire pwrLvl = pwrSync_r[1];
  wire rstLvl = rstSync_r[1];

  // Millisecond tick; times here are seconds so a slow tick is plenty
  reg [16:0] divCnt_r;
  reg tick_r;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      divCnt_r <= 17'h00000;
      tick_r <= 1'b0;
    end else if (divCnt_r == TICK_DIV - 1) begin
      divCnt_r <= 17'h00000;
      tick_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  wire [15:0] pwrLowMs;
  mpors_low_timer #(.W(16)) uPwrLow (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(tick_r),
    .lowIn(pwrLvl),
    .lowMs_r(pwrLowMs)
  );

  // Reset-request low time counted locally; reset is level plus duration
  reg [15:0] rstLowMs_r;
  always @(posedge sys_clk) begin
    if (sys_rst || rstLvl) begin
      rstLowMs_r <= 16'h0000;
    end else begin
      rstLowMs_r <= msStep(rstLowMs_r, tick_r);
    end
  end

  // Pulse classification acts on the release edge, so a long pulse is never
  // mistaken for a short one while it is still held
  reg pwrLvlD_r;
  reg [15:0] pwrHeldMs_r;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pwrLvlD_r <= 1'b1;
      pwrHeldMs_r <= 16'h0000;
    end else begin
      pwrLvlD_r <= pwrLvl;
      pwrHeldMs_r <= pwrLowMs;
    end
  end
  wire pwrRelease = pwrLvl && !pwrLvlD_r;
  wire onPulse = pwrRelease && pwrHeldMs_r >= ON_PULSE_MS;
  // Pulses longer than the typical 3 s are still accepted as off requests
  wire offPulse = pwrRelease && pwrHeldMs_r >= OFF_PULSE_MS;
  wire rstHeld = !rstLvl && rstLowMs_r >= RST_PULSE_MS;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] waitMs_r;
  reg [15:0] waitMs_nxt;
  reg [15:0] limitMs_r;
  reg [15:0] limitMs_nxt;

  always @* begin
    state_nxt = state_r;
    waitMs_nxt = waitMs_r;
    limitMs_nxt = limitMs_r;
    waitMs_nxt = msStep(waitMs_r, tick_r);
    case (state_r)
      ST_OFF: begin
        if (onPulse) begin
          state_nxt = ST_BOOT;
          waitMs_nxt = 16'h0000;
          limitMs_nxt = BOOT_LIM[15:0];
        end
      end
      ST_BOOT, ST_RESTART: begin
        if (waitMs_r >= limitMs_r) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (offPulse) begin
          state_nxt = ST_SHUTDOWN;
          waitMs_nxt = 16'h0000;
          limitMs_nxt = OFF_LIM[15:0];
        end else if (shutdown_command) begin
          state_nxt = ST_SHUTDOWN;
          waitMs_nxt = 16'h0000;
          limitMs_nxt = CMD_OFF_LIM[15:0];
        end else if (restart_command) begin
          state_nxt = ST_RESTART;
          waitMs_nxt = 16'h0000;
          limitMs_nxt = RESTART_LIM[15:0];
        end
      end
      ST_SHUTDOWN: begin
        // Supply must still be present here; the host holds it the full time
        if (waitMs_r >= limitMs_r) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // A held reset restarts the system from any powered state except shutdown
    if (rstHeld && state_r != ST_OFF && state_r != ST_SHUTDOWN) begin
      state_nxt = ST_RESTART;
      waitMs_nxt = 16'h0000;
      limitMs_nxt = RESTART_LIM[15:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_OFF;
      waitMs_r <= 16'h0000;
      limitMs_r <= 16'h0000;
      moduleOn_r <= 1'b0;
      cmdPortReady_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      waitMs_r <= waitMs_nxt;
      limitMs_r <= limitMs_nxt;
      moduleOn_r <= (state_nxt != ST_OFF);
      cmdPortReady_r <= (state_nxt == ST_ON);
    end
  end

  // Card detection
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cardDetectEn_r <= 1'b0;
      cardPresent_r <= 1'b0;
    end else begin
      if (card_detect_enable_command) begin
        cardDetectEn_r <= cardDetectArg;
      end
      cardPresent_r <= cardDetectEn_r && !cardSync_r[1];
    end
  end
endmodule // mpors_sequencer

// file: verif/mpors_host.sv
// Host model that pulses the power control or reset request pin low
`timescale 1ns/1ps
module mpors_host (
  input wire sys_clk,
  input wire start,
  input wire pinSel,
  input wire [15:0] lowLen,
  output wire powerCtrlIn,
  output wire resetReqIn
);
  reg [15:0] left_r = 16'h0000;
  wire busy = (left_r != 16'h0000);
  // Pins idle high as the pull-ups leave them
  assign powerCtrlIn = !(busy && !pinSel);
  assign resetReqIn = !(busy && pinSel);
  always @(posedge sys_clk) begin
    if (start) left_r <= lowLen;
    else if (busy) left_r <= left_r - 16'h0001;
  end
endmodule // mpors_host

// file: verif/mpors_monitor.sv
// Port checker for the power sequencer
`timescale 1ns/1ps
module mpors_monitor #(
  parameter TICK_DIV = 4,
  parameter OFF_DONE_MS = 22,
  parameter CMD_OFF_DONE_MS = 15,
  parameter RESTART_READY_MS = 27
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire card_presence_in,
  input wire shutdown_command,
  input wire restart_command,
  input wire moduleOn_r,
  input wire cmdPortReady_r,
  input wire cardPresent_r,
  input wire cardDetectEn_r,
  input wire powerCtrlPullUp,
  input wire cardPresencePullUp
);
  reg [15:0] waitCnt_r;
  reg cmdOff_r;
  // Cycles spent powered but not ready; one tick of slack for tick phase
  always @(posedge sys_clk) begin
    waitCnt_r <= (moduleOn_r && !cmdPortReady_r) ? waitCnt_r + 16'h0001 : 16'h0000;
    if (sys_rst || !moduleOn_r) cmdOff_r <= 1'b0;
    else if (shutdown_command && cmdPortReady_r) cmdOff_r <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_pull; powerCtrlPullUp && cardPresencePullUp; endproperty
  property p_in; (cardDetectEn_r && !card_presence_in)[*6] |-> cardPresent_r; endproperty
  property p_out; (card_presence_in || !cardDetectEn_r)[*6] |-> !cardPresent_r; endproperty
  property p_pinOff; $fell(moduleOn_r) && !cmdOff_r |-> waitCnt_r >= (OFF_DONE_MS-1)*TICK_DIV;
  endproperty
  property p_cmdOff; $fell(moduleOn_r) |-> waitCnt_r >= (CMD_OFF_DONE_MS-1)*TICK_DIV; endproperty
  property p_take; shutdown_command && cmdPortReady_r |=> moduleOn_r && !cmdPortReady_r; endproperty
  property p_rst; restart_command && cmdPortReady_r && !shutdown_command |=> !cmdPortReady_r;
  endproperty
  property p_ready; $rose(cmdPortReady_r) |-> waitCnt_r >= (RESTART_READY_MS-1)*TICK_DIV; endproperty
  a_pull: assert property (p_pull) else $error("pull-up off");
  a_in: assert property (p_in) else $error("card not present");
  a_out: assert property (p_out) else $error("card not absent");
  a_pinOff: assert property (p_pinOff) else $error("pin shutdown short");
  a_cmdOff: assert property (p_cmdOff) else $error("command shutdown short");
  a_take: assert property (p_take) else $error("shutdown not taken");
  a_rst: assert property (p_rst) else $error("restart not taken");
  a_ready: assert property (p_ready) else $error("ready too soon");
  c_ready: cover property ($rose(cmdPortReady_r));
  c_off: cover property ($fell(moduleOn_r));
  c_card: cover property ($rose(cardPresent_r));
endmodule // mpors_monitor
bind mpors_sequencer mpors_monitor #(.TICK_DIV(TICK_DIV), .OFF_DONE_MS(OFF_DONE_MS),
  .CMD_OFF_DONE_MS(CMD_OFF_DONE_MS), .RESTART_READY_MS(RESTART_READY_MS)) u_mon (.sys_clk,
  .sys_rst, .card_presence_in, .shutdown_command, .restart_command, .moduleOn_r,
  .cmdPortReady_r, .cardPresent_r, .cardDetectEn_r, .powerCtrlPullUp, .cardPresencePullUp);

// file: verif/test_module_power_off_reset_sequencing.sv
// Bench for the power sequencer
`timescale 1ns/1ps
module test_module_power_off_reset_sequencing;
  localparam TD = 4;
  // Scaled-down millisecond counts so every power cycle fits in a short run
  localparam ONMS = 3, OFFMS = 10, PINOFF = 22, CMDOFF = 15, RSTMS = 5, READYMS = 27;
  reg sys_clk = 0, sys_rst = 1, start = 0, pinSel = 0, card_presence_in = 1, cardDetectArg = 0;
  reg shutdown_command = 0, restart_command = 0, card_detect_enable_command = 0;
  reg [15:0] lowLen = 16'h0000;
  reg [3:0] last = 4'h0;
  reg [3:0] expQ[$];
  wire powerCtrlIn, resetReqIn, moduleOn_r, cmdPortReady_r, cardPresent_r, cardDetectEn_r;
  wire pullPwr, pullCard;
  wire [3:0] st = {moduleOn_r, cmdPortReady_r, cardPresent_r, cardDetectEn_r};
  integer mismatches = 0, totalChecks = 0, k;
  always #4 sys_clk = ~sys_clk;
  mpors_host HOST (.sys_clk, .start, .pinSel, .lowLen, .powerCtrlIn, .resetReqIn);
  mpors_sequencer #(.TICK_DIV(TD), .ON_PULSE_MS(ONMS), .OFF_PULSE_MS(OFFMS),
    .OFF_DONE_MS(PINOFF), .CMD_OFF_DONE_MS(CMDOFF), .RST_PULSE_MS(RSTMS),
    .RESTART_READY_MS(READYMS), .BOOT_MS(READYMS)) DUT (
    .sys_clk, .sys_rst, .powerCtrlIn, .resetReqIn, .card_presence_in, .shutdown_command,
    .restart_command, .card_detect_enable_command, .cardDetectArg, .moduleOn_r,
    .cmdPortReady_r, .cardPresent_r, .cardDetectEn_r, .powerCtrlPullUp(pullPwr),
    .cardPresencePullUp(pullCard));
  task bad(input [3:0] v);
    mismatches = mismatches + 1;
    $display("BAD %0t outputs %b", $time, v);
  endtask
  // Every output change must match the oldest expectation
  always @(negedge sys_clk) begin
    if (!sys_rst && st !== last) begin
      totalChecks = totalChecks + 1;
      if (expQ.size() == 0 || expQ[0] !== st) bad(st);
      if (expQ.size() != 0) expQ.pop_front();
    end
    last <= st;
  end
  task ex(input [3:0] v);
    expQ.push_back(v);
  endtask
  task drain(input integer ms);
    repeat (ms * TD + 20) @(posedge sys_clk);
    totalChecks = totalChecks + 1;
    if (expQ.size() != 0) bad(st);
  endtask
  task pulse(input sel, input [15:0] len);
    @(posedge sys_clk) begin pinSel <= sel; lowLen <= len + ($urandom % TD); start <= 1'b1; end
    @(posedge sys_clk) start <= 1'b0;
    repeat (len + TD) @(posedge sys_clk);
  endtask
  task cmd(input integer c, input arg);
    @(posedge sys_clk) begin
      shutdown_command <= c == 0;
      restart_command <= c == 1;
      card_detect_enable_command <= c == 2;
      cardDetectArg <= arg;
    end
    @(posedge sys_clk) {shutdown_command, restart_command, card_detect_enable_command} <= 3'h0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    k = $urandom(61);
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cmd(0, 0);
    pulse(0, TD);
    drain(2);
    ex(4'h8); ex(4'hC); pulse(0, 4 * TD); drain(30);
    ex(4'hD); cmd(2, 1); drain(1);
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge sys_clk) card_presence_in <= ~card_presence_in;
      ex(card_presence_in ? 4'hF : 4'hD);
      repeat ($urandom % 8 + 8) @(posedge sys_clk);
    end
    ex(4'hC); cmd(2, 0); drain(1);
    ex(4'h8); ex(4'hC); cmd(1, 0); drain(30);
    ex(4'h8); ex(4'hC); pulse(1, 7 * TD); drain(30);
    ex(4'h8); ex(4'h0); cmd(0, 0); drain(16);
    ex(4'h8); ex(4'hC); pulse(0, 4 * TD); drain(30);
    ex(4'h8); ex(4'h0); pulse(0, 12 * TD); drain(24);
    totalChecks = totalChecks + 1;
    if (pullPwr !== 1'b1 || pullCard !== 1'b1) bad(st);
    results;
  end
endmodule // test_module_power_off_reset_sequencing
